/* core/float_to_int_store_convert.sv */
// converter from extended float operands to 16, 32 or 64 bit integer stores
// Notes on behaviour
// - targets of 16, 32 and 64 bits
// - masked overflow stores the most negative integer
// - overflow always sets the invalid operation flag
// - overflow never sets the precision flag
// - unmasked overflow: no store, operand kept
// - unmasked overflow vectors to the exception handler
// - popping variant pops unless an unmasked trap
// - range check identical in all rounding modes
// - 16-bit range is -32768 to +32767
// - 32-bit range is -2147483648 to +2147483647
// - every large negative magnitude overflows, any mantissa
module float_to_int_store_convert
   import float_to_int_store_pkg::*;
(
   input wire logic CLK_SYS_IN,
   input wire logic RESET_IN,
   input wire logic OP_VALID_IN,
   input wire store_request_s OP_REQUEST_IN,
   output logic STORE_VALID_OUT,
   output store_write_s STORE_WRITE_OUT,
   output logic POP_OUT,
   output logic TRAP_OUT,
   output logic DONE_OUT,
   output logic IRQ_OUT,
   input wire logic [3:0] REG_ADDR_IN,
   input wire logic [31:0] REG_WDATA_IN,
   input wire logic REG_WRITE_IN,
   input wire logic REG_READ_IN,
   output logic [31:0] REG_RDATA_OUT
);

   // width decode used by both the range limit and the overflow pattern
   function automatic logic [6:0] width_bits(input target_width_e w);
      logic [6:0] b;
      b = 7'd64;
      if (w == WIDTH_16) begin
         b = 7'd16;
      end else if (w == WIDTH_32) begin
         b = 7'd32;
      end
      return b;
   endfunction : width_bits

   // largest magnitude that fits: 2^(n-1) for negative, 2^(n-1)-1 for positive
   function automatic logic [64:0] max_magnitude(input target_width_e w, input logic neg);
      logic [64:0] top;
      top = 65'h1 << (width_bits(w) - 7'd1);
      return neg ? top : top - 65'h1;
   endfunction : max_magnitude

   function automatic logic [63:0] most_negative_integer(input target_width_e w);
      return 64'h1 << (width_bits(w) - 7'd1);
   endfunction : most_negative_integer

   function automatic logic [63:0] width_mask(input target_width_e w);
      logic [63:0] m;
      m = 64'hFFFF_FFFF_FFFF_FFFF;
      if (w == WIDTH_16) begin
         m = 64'h0000_0000_0000_FFFF;
      end else if (w == WIDTH_32) begin
         m = 64'h0000_0000_FFFF_FFFF;
      end
      return m;
   endfunction : width_mask

   logic invalid_mask;
   round_mode_e round_mode;
   logic [1:0] status;
   logic [1:0] irq_mask;
   logic [63:0] last_result;
   logic result_invalid;
   logic result_inexact;

   operand_s opnd;
   target_width_e width;
   logic signed [16:0] unbiased;
   logic [16:0] shift_full;
   logic [6:0] shift;
   logic [128:0] aligned;
   logic [63:0] int_part;
   logic guard;
   logic sticky;
   logic round_up;
   logic [64:0] magnitude;
   logic [64:0] negated;
   logic nan_or_inf;
   logic exp_too_big;
   logic exp_tiny;
   logic out_of_range;
   logic inexact;
   logic trap;
   logic [63:0] next_result;
   logic [1:0] status_set;
   logic [1:0] status_clear;
   logic [1:0] next_status;

   assign opnd = OP_REQUEST_IN.operand;
   assign width = OP_REQUEST_IN.width;

   // alignment: the guard and 64 sticky bits sit below the integer part
   always_comb begin
      unbiased = $signed({2'b00, opnd.exponent}) - $signed(EXP_BIAS);
      exp_too_big = unbiased > 17'sd63;
      exp_tiny = unbiased < -17'sd1;
      shift_full = 17'd63 - unbiased;
      shift = (exp_too_big || exp_tiny) ? 7'd0 : shift_full[6:0];
      aligned = {opnd.mantissa, 65'h0} >> shift;
      if (exp_tiny) begin
         // below one half: nothing of the integer survives
         int_part = 64'h0;
         guard = 1'b0;
         sticky = |opnd.mantissa;
      end else begin
         int_part = aligned[128:65];
         guard = aligned[64];
         sticky = |aligned[63:0];
      end
   end

   // rounding follows the live control field
   always_comb begin
      round_up = 1'b0;
      case (round_mode)
         ROUND_NEAREST: round_up = guard && (sticky || int_part[0]);
         ROUND_DOWN: round_up = opnd.sign && (guard || sticky);
         ROUND_UP: round_up = !opnd.sign && (guard || sticky);
         default: round_up = 1'b0;
      endcase
   end

   assign magnitude = {1'b0, int_part} + {64'h0, round_up};
   assign negated = ~magnitude + 65'h1;
   assign inexact = guard || sticky;
   assign nan_or_inf = opnd.exponent == EXP_ALL_ONES;

   // one limit check on the rounded magnitude, whatever the mode; huge
   // exponents are caught before any mantissa bit is looked at
   assign out_of_range = nan_or_inf || exp_too_big ||
                         (magnitude > max_magnitude(width, opnd.sign));

   assign trap = OP_VALID_IN && out_of_range && !invalid_mask;

   always_comb begin
      if (out_of_range) begin
         next_result = most_negative_integer(width);
      end else if (opnd.sign) begin
         next_result = negated[63:0] & width_mask(width);
      end else begin
         next_result = magnitude[63:0] & width_mask(width);
      end
   end

   // store path, pop and trap: all outputs leave from flops
   always_ff @(posedge CLK_SYS_IN) begin
      if (RESET_IN) begin
         STORE_VALID_OUT <= 1'b0;
         STORE_WRITE_OUT <= '{width: WIDTH_16, data: RESULT_RESET};
         POP_OUT <= 1'b0;
         TRAP_OUT <= 1'b0;
         DONE_OUT <= 1'b0;
         result_invalid <= 1'b0;
         result_inexact <= 1'b0;
         last_result <= RESULT_RESET;
      end else begin
         STORE_VALID_OUT <= OP_VALID_IN && !trap;
         POP_OUT <= OP_VALID_IN && OP_REQUEST_IN.pop && !trap;
         TRAP_OUT <= trap;
         DONE_OUT <= OP_VALID_IN;
         if (OP_VALID_IN) begin
            STORE_WRITE_OUT <= '{width: width, data: next_result};
            result_invalid <= out_of_range;
            result_inexact <= inexact && !out_of_range;
            if (!trap) begin
               last_result <= next_result;
            end
         end
      end
   end

   // sticky flags; a new event wins over a write-one-to-clear
   always_comb begin
      status_set = 2'b00;
      status_clear = 2'b00;
      if (OP_VALID_IN) begin
         status_set[INVALID_OPERATION_FLAG_POS] = out_of_range;
         // precision only on an in-range inexact result
         status_set[PRECISION_FLAG_POS] = !out_of_range && inexact;
      end
      if (REG_WRITE_IN && REG_ADDR_IN == STATUS_OFFSET) begin
         status_clear = REG_WDATA_IN[1:0];
      end
      next_status = (status & ~status_clear) | status_set;
   end

   always_ff @(posedge CLK_SYS_IN) begin
      if (RESET_IN) begin
         status <= STATUS_RESET;
      end else begin
         status <= next_status;
      end
   end

   // software control writes
   always_ff @(posedge CLK_SYS_IN) begin
      if (RESET_IN) begin
         invalid_mask <= CTRL_INVALID_MASK_RESET;
         round_mode <= round_mode_e'(CTRL_ROUND_RESET);
         irq_mask <= IRQ_MASK_RESET;
      end else if (REG_WRITE_IN) begin
         if (REG_ADDR_IN == CTRL_OFFSET) begin
            invalid_mask <= REG_WDATA_IN[CTRL_INVALID_MASK_POS];
            round_mode <= round_mode_e'(REG_WDATA_IN[CTRL_ROUND_LSB_POS +: 2]);
         end else if (REG_ADDR_IN == IRQ_MASK_OFFSET) begin
            irq_mask <= REG_WDATA_IN[1:0];
         end
      end
   end

   // read data only in the cycle after the strobe; unmapped reads as zero
   always_ff @(posedge CLK_SYS_IN) begin
      if (RESET_IN) begin
         REG_RDATA_OUT <= 32'h0;
      end else if (!REG_READ_IN) begin
         REG_RDATA_OUT <= 32'h0;
      end else if (REG_ADDR_IN == CTRL_OFFSET) begin
         REG_RDATA_OUT <= {29'h0, round_mode, invalid_mask};
      end else if (REG_ADDR_IN == STATUS_OFFSET) begin
         REG_RDATA_OUT <= {30'h0, status};
      end else if (REG_ADDR_IN == IRQ_MASK_OFFSET) begin
         REG_RDATA_OUT <= {30'h0, irq_mask};
      end else if (REG_ADDR_IN == LAST_RESULT_OFFSET) begin
         REG_RDATA_OUT <= last_result[31:0];
      end else begin
         REG_RDATA_OUT <= 32'h0;
      end
   end

   // irq built from next_status so it rises with the flag yet leaves a flop
   always_ff @(posedge CLK_SYS_IN) begin
      if (RESET_IN) begin
         IRQ_OUT <= 1'b0;
      end else begin
         IRQ_OUT <= |(next_status & irq_mask);
      end
   end

   trap_no_store_a: assert property (
      @(posedge CLK_SYS_IN) disable iff (RESET_IN)
      TRAP_OUT |-> !STORE_VALID_OUT && !POP_OUT)
      else $error("store or pop issued alongside a trap");

   trap_cause_a: assert property (
      @(posedge CLK_SYS_IN) disable iff (RESET_IN)
      $past(OP_VALID_IN) && result_invalid && !$past(invalid_mask) |-> TRAP_OUT)
      else $error("unmasked overflow did not trap");

   invalid_flag_a: assert property (
      @(posedge CLK_SYS_IN) disable iff (RESET_IN)
      DONE_OUT && result_invalid |-> status[INVALID_OPERATION_FLAG_POS])
      else $error("overflow left the invalid flag clear");

   no_precision_a: assert property (
      @(posedge CLK_SYS_IN) disable iff (RESET_IN)
      DONE_OUT && result_invalid |->
         !(status[PRECISION_FLAG_POS] && !$past(status[PRECISION_FLAG_POS])))
      else $error("overflow raised the precision flag");

   masked_most_negative_integer_a: assert property (
      @(posedge CLK_SYS_IN) disable iff (RESET_IN)
      STORE_VALID_OUT && result_invalid |->
         STORE_WRITE_OUT.data == most_negative_integer(STORE_WRITE_OUT.width))
      else $error("masked overflow stored a wrong pattern");

   pop_after_store_a: assert property (
      @(posedge CLK_SYS_IN) disable iff (RESET_IN)
      OP_VALID_IN && OP_REQUEST_IN.pop |=> POP_OUT == !TRAP_OUT && DONE_OUT)
      else $error("pop does not follow the completed store");

   range16_edge_a: assert property (
      @(posedge CLK_SYS_IN) disable iff (RESET_IN)
      OP_VALID_IN && width == WIDTH_16 && opnd.exponent == 15'h400E &&
         opnd.mantissa == 64'h8000_0000_0000_0000 |=> result_invalid == !$past(opnd.sign))
      else $error("16-bit edge of 2^15 misjudged");

   range32_edge_a: assert property (
      @(posedge CLK_SYS_IN) disable iff (RESET_IN)
      OP_VALID_IN && width == WIDTH_32 && opnd.exponent == 15'h401E &&
         opnd.mantissa == 64'h8000_0000_0000_0000 |=> result_invalid == !$past(opnd.sign))
      else $error("32-bit edge of 2^31 misjudged");

   huge_negative_a: assert property (
      @(posedge CLK_SYS_IN) disable iff (RESET_IN)
      OP_VALID_IN && opnd.sign && opnd.exponent >= 15'h403F |=> result_invalid)
      else $error("large negative operand not flagged");

   inexact_flag_a: assert property (
      @(posedge CLK_SYS_IN) disable iff (RESET_IN)
      DONE_OUT && result_inexact |-> status[PRECISION_FLAG_POS] && STORE_VALID_OUT)
      else $error("inexact result without precision flag");

   done_latency_a: assert property (
      @(posedge CLK_SYS_IN) disable iff (RESET_IN)
      OP_VALID_IN |=> DONE_OUT && (STORE_VALID_OUT != TRAP_OUT))
      else $error("conversion did not complete in one cycle");

endmodule : float_to_int_store_convert

/* core/float_to_int_store_pkg.sv */
// shared constants and carrier types for the float to integer store converter
package float_to_int_store_pkg;
   // register offsets on the plain register port (byte addresses)
   localparam logic [3:0] CTRL_OFFSET = 4'h0;
   localparam logic [3:0] STATUS_OFFSET = 4'h4;
   localparam logic [3:0] IRQ_MASK_OFFSET = 4'h8;
   localparam logic [3:0] LAST_RESULT_OFFSET = 4'hC;
   // control field positions and reset values
   localparam int CTRL_INVALID_MASK_POS = 0;
   localparam int CTRL_ROUND_LSB_POS = 1;
   localparam logic CTRL_INVALID_MASK_RESET = 1'b1;
   localparam logic [1:0] CTRL_ROUND_RESET = 2'h0;
   // status and irq mask field positions and reset values
   localparam int INVALID_OPERATION_FLAG_POS = 0;
   localparam int PRECISION_FLAG_POS = 1;
   localparam logic [1:0] STATUS_RESET = 2'h0;
   localparam logic [1:0] IRQ_MASK_RESET = 2'h0;
   // extended format constants
   localparam logic [16:0] EXP_BIAS = 17'h03FFF;
   localparam logic [14:0] EXP_ALL_ONES = 15'h7FFF;
   localparam logic [63:0] RESULT_RESET = 64'h0;

   typedef enum logic [1:0] {
      ROUND_NEAREST,
      ROUND_DOWN,
      ROUND_UP,
      ROUND_ZERO
   } round_mode_e;

   typedef enum logic [1:0] {
      WIDTH_16,
      WIDTH_32,
      WIDTH_64
   } target_width_e;

   typedef struct packed {
      logic sign;
      logic [14:0] exponent;
      logic [63:0] mantissa;
   } operand_s;

   typedef struct packed {
      logic pop;
      target_width_e width;
      operand_s operand;
   } store_request_s;

   typedef struct packed {
      target_width_e width;
      logic [63:0] data;
   } store_write_s;
endpackage : float_to_int_store_pkg

/* dv/float_to_int_store_convert_tb.sv */
// self-checking bench for the float to integer store converter
module float_to_int_store_convert_tb
   import float_to_int_store_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;

   logic clk = 1'b0;
   logic rst = 1'b1;
   logic op_valid = 1'b0;
   logic reg_write = 1'b0;
   logic reg_read = 1'b0;
   store_request_s op_req = '0;
   logic [3:0] reg_addr = 4'h0;
   logic [31:0] reg_wdata = 32'h0;
   logic store_valid, pop, trap, done, irq;
   store_write_s store_write;
   logic [31:0] reg_rdata;
   int mismatches = 0;
   int n_compared = 0;
   logic [63:0] pos_tab [4] = '{64'h2, 64'h2, 64'h3, 64'h2};
   logic [63:0] neg_tab [4] = '{64'hFFFFFFFE, 64'hFFFFFFFD, 64'hFFFFFFFE, 64'hFFFFFFFE};

   float_to_int_store_convert u_float_to_int_store_convert (
      .CLK_SYS_IN(clk), .RESET_IN(rst), .OP_VALID_IN(op_valid), .OP_REQUEST_IN(op_req),
      .STORE_VALID_OUT(store_valid), .STORE_WRITE_OUT(store_write), .POP_OUT(pop),
      .TRAP_OUT(trap), .DONE_OUT(done), .IRQ_OUT(irq), .REG_ADDR_IN(reg_addr),
      .REG_WDATA_IN(reg_wdata), .REG_WRITE_IN(reg_write), .REG_READ_IN(reg_read),
      .REG_RDATA_OUT(reg_rdata));

   initial begin
      forever #2 clk = ~clk;
   end

   task automatic complete_run();
      $display("comparisons %0d mismatches %0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : complete_run

   task automatic check_bit(input logic got, input logic want, input string what);
      n_compared++;
      if (got !== want) begin
         mismatches++;
         $display("unexpected %s at %0t: got %b want %b", what, $time, got, want);
      end
   endtask : check_bit

   task automatic check_word(input logic [63:0] got, input logic [63:0] want, input string what);
      n_compared++;
      if (got !== want) begin
         mismatches++;
         $display("unexpected %s at %0t: got %h want %h", what, $time, got, want);
      end
   endtask : check_word

   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_write <= 1'b1;
      @(posedge clk);
      reg_write <= 1'b0;
   endtask : wr

   task automatic rd(input logic [3:0] a, input logic [31:0] want);
      @(posedge clk);
      reg_addr <= a;
      reg_read <= 1'b1;
      @(posedge clk);
      reg_read <= 1'b0;
      #1;
      check_word({32'h0, reg_rdata}, {32'h0, want}, "read data");
   endtask : rd

   // magnitude m scaled down by 2^frac, normalised with explicit integer bit
   function automatic operand_s make_op(input logic s, input logic [63:0] m, input int frac);
      int p;
      operand_s o;
      p = 63;
      while (p > 0 && m[p] !== 1'b1) p--;
      o.sign = s;
      o.exponent = 15'(int'(EXP_BIAS) + p - frac);
      o.mantissa = m << (63 - p);
      return o;
   endfunction : make_op

   // status cleared first so each flag check sees only this conversion
   task automatic conv(input logic p, input target_width_e w, input logic s,
                       input logic [63:0] m, input int frac, input logic t,
                       input logic [63:0] d, input logic [1:0] st);
      wr(STATUS_OFFSET, 32'h3);
      @(posedge clk);
      op_req <= '{pop: p, width: w, operand: make_op(s, m, frac)};
      op_valid <= 1'b1;
      @(posedge clk);
      op_valid <= 1'b0;
      #1;
      check_bit(done, 1'b1, "done");
      check_word(64'(store_write.width), 64'(w), "store width");
      check_bit(trap, t, "trap");
      check_bit(store_valid, !t, "store strobe");
      check_bit(pop, p && !t, "pop");
      if (!t) begin
         check_word(store_write.data, d, "store data");
      end
      rd(STATUS_OFFSET, {30'h0, st});
   endtask : conv

   initial begin
      repeat (20000) @(posedge clk);
      mismatches++;
      complete_run();
   end

   initial begin
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      rd(CTRL_OFFSET, 32'h1);
      rd(STATUS_OFFSET, 32'h0);
      rd(IRQ_MASK_OFFSET, 32'h0);
      rd(LAST_RESULT_OFFSET, 32'h0);
      wr(4'h3, 32'h7);
      rd(4'h2, 32'h0);
      rd(CTRL_OFFSET, 32'h1);
      // boundaries of each width, masked invalid
      conv(0, WIDTH_16, 0, 64'h7FFF, 0, 0, 64'h7FFF, 2'h0);
      conv(0, WIDTH_16, 1, 64'h8000, 0, 0, 64'h8000, 2'h0);
      conv(1, WIDTH_16, 0, 64'h8000, 0, 0, 64'h8000, 2'h1);
      conv(0, WIDTH_16, 1, 64'h20001, 2, 0, 64'h8000, 2'h2);
      conv(0, WIDTH_16, 1, 64'h8001, 0, 0, 64'h8000, 2'h1);
      conv(0, WIDTH_32, 0, 64'h7FFFFFFF, 0, 0, 64'h7FFFFFFF, 2'h0);
      conv(0, WIDTH_32, 1, 64'h80000000, 0, 0, 64'h80000000, 2'h0);
      conv(0, WIDTH_32, 0, 64'hFFFFFFFF, 1, 0, 64'h80000000, 2'h1);
      conv(0, WIDTH_32, 1, 64'h300000003, 1, 0, 64'h80000000, 2'h1);
      conv(0, WIDTH_32, 1, 64'hFFFF800000000001, 2, 0, 64'h80000000, 2'h1);
      conv(0, WIDTH_64, 0, 64'h7FFFFFFFFFFFFFFF, 0, 0, 64'h7FFFFFFFFFFFFFFF, 2'h0);
      conv(0, WIDTH_64, 1, 64'h8000000000000000, 0, 0, 64'h8000000000000000, 2'h0);
      conv(0, WIDTH_64, 0, 64'h8000000000000000, 0, 0, 64'h8000000000000000, 2'h1);
      // every rounding mode: inexact values and far negative overflows at 16 and 32 bits
      for (int md = 0; md < 4; md++) begin
         wr(CTRL_OFFSET, 32'(md * 2 + 1));
         conv(0, WIDTH_32, 0, 64'h5, 1, 0, pos_tab[md], 2'h2);
         conv(0, WIDTH_32, 1, 64'h5, 1, 0, neg_tab[md], 2'h2);
         conv(1, WIDTH_16, 1, 64'h30003, 1, 0, 64'h8000, 2'h1);
         conv(0, WIDTH_32, 1, 64'h300000003, 1, 0, 64'h80000000, 2'h1);
      end
      // unmasked: in range stores and pops, out of range traps
      wr(CTRL_OFFSET, 32'h0);
      conv(1, WIDTH_32, 0, 64'h4D2, 0, 0, 64'h4D2, 2'h0);
      conv(1, WIDTH_16, 1, 64'h186A0, 0, 1, 64'h0, 2'h1);
      conv(0, WIDTH_32, 0, 64'h80000000, 0, 1, 64'h0, 2'h1);
      rd(LAST_RESULT_OFFSET, 32'h4D2);
      // interrupt raised, masked and cleared
      wr(IRQ_MASK_OFFSET, 32'h1);
      rd(IRQ_MASK_OFFSET, 32'h1);
      #1;
      check_bit(irq, 1'b1, "irq raised");
      wr(IRQ_MASK_OFFSET, 32'h2);
      repeat (2) @(posedge clk);
      #1;
      check_bit(irq, 1'b0, "irq masked");
      wr(IRQ_MASK_OFFSET, 32'h1);
      repeat (2) @(posedge clk);
      #1;
      check_bit(irq, 1'b1, "irq unmasked");
      wr(STATUS_OFFSET, 32'h1);
      repeat (2) @(posedge clk);
      #1;
      check_bit(irq, 1'b0, "irq cleared");
      rd(STATUS_OFFSET, 32'h0);
      complete_run();
   end
endmodule : float_to_int_store_convert_tb
